// ==== verilog/cilc_pkg.sv ====
// Constants, types and decode helpers for the charger input limit registers
package cilc_pkg;

   // Clock rate of the block
   localparam int unsigned CLK_MHZ = 100;

   // Register addresses on the serial bus
   localparam logic [7:0] ADDR_TIMER_EVT_MASK = 8'h12;
   localparam logic [7:0] ADDR_LIMIT_A = 8'h13;
   localparam logic [7:0] ADDR_LIMIT_B = 8'h14;
   localparam logic [7:0] ADDR_UNDERVOLT = 8'h16;
   localparam logic [7:0] ADDR_ZONE_ONE = 8'h17;
   localparam logic [7:0] ADDR_ZONE_TWO = 8'h18;
   localparam logic [7:0] ADDR_MAIN_CTRL = 8'h19;

   // Writable bits of each register; reserved bits hold zero
   localparam logic [7:0] WMASK_TIMER_EVT = 8'h81;
   localparam logic [7:0] WMASK_LIMIT_A = 8'hFF;
   localparam logic [7:0] WMASK_LIMIT_B = 8'h2F;
   localparam logic [7:0] WMASK_UNDERVOLT = 8'hC0;
   localparam logic [7:0] WMASK_ZONE = 8'h7F;
   localparam logic [7:0] WMASK_MAIN_CTRL = 8'hEF;

   // Values after reset
   localparam logic [7:0] RST_TIMER_EVT = 8'h00;
   localparam logic [7:0] RST_LIMIT_A = 8'h00;
   localparam logic [7:0] RST_LIMIT_B = 8'h00;
   localparam logic [7:0] RST_UNDERVOLT = 8'h00;
   localparam logic [7:0] RST_ZONE = 8'h00;
   localparam logic [7:0] RST_MAIN_CTRL = 8'h00;
   localparam logic [4:0] RST_SYNC = 5'h03;

   // Field positions
   localparam int WD_MASK_BIT = 7;
   localparam int BT_MASK_BIT = 0;
   localparam int BLANK_LSB = 6;
   localparam int CEIL_LSB = 3;
   localparam int STEADY_LSB = 0;
   localparam int DISCHARGE_BIT = 5;
   localparam int MINV_LSB = 0;
   localparam int LOCKOUT_LSB = 6;
   localparam int CHG_ON_BIT = 7;
   localparam int AUTOSTOP_BIT = 6;
   localparam int RESTART_BIT = 5;
   localparam int FORCE_MON_BIT = 3;
   localparam int ROOM_ONLY_BIT = 2;
   localparam int TIME_LIM_BIT = 1;
   localparam int PHASE1_EN_BIT = 0;

   // Blanking times and bus inactivity limit
   localparam real BLANK_A_MS = 0.5;
   localparam real BLANK_B_MS = 1.0;
   localparam real BLANK_C_MS = 10.0;
   localparam real BUS_TIMEOUT_MS = 100.0;
   localparam int unsigned BLANK_RESAMPLE_CYC = 4;

   // Charge current decode
   localparam logic [6:0] CUR_LO_TOP = 7'h3F;
   localparam logic [6:0] CUR_HI_FIRST = 7'h40;
   localparam logic [6:0] CUR_HI_TOP = 7'h64;
   localparam logic [9:0] CUR_LO_BASE = 10'h004;
   localparam logic [9:0] CUR_HI_BASE = 10'h08C;
   localparam logic [9:0] CUR_HI_STEP = 10'h00A;
   localparam logic [9:0] CUR_SAT = 10'h1F4;

   // Serial slave states
   typedef enum logic [4:0] {
      S_IDLE = 5'h01,
      S_RX = 5'h02,
      S_ACK_RX = 5'h04,
      S_TX = 5'h08,
      S_ACK_TX = 5'h10
   } cilc_state_e;

   // Milliamps from a seven-bit charge current code
   function automatic logic [9:0] cilc_code_to_ma(input logic [6:0] code);
      logic [9:0] c;
      c = {3'h0, code};
      if (code <= CUR_LO_TOP) begin
         return CUR_LO_BASE + (c << 1);
      end else if (code <= CUR_HI_TOP) begin
         return CUR_HI_BASE + 10'((c - {3'h0, CUR_HI_FIRST}) * CUR_HI_STEP);
      end
      return CUR_SAT;
   endfunction : cilc_code_to_ma

endpackage : cilc_pkg

// ==== verilog/cilc_sync.sv ====
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module cilc_sync
   import cilc_pkg::*;
#(
   parameter int W = 5,
   parameter logic [W-1:0] P_RST = '0
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Asynchronous inputs and filtered result
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_q
);

   typedef struct packed {
      logic [W-1:0] f1;
      logic [W-1:0] f2;
      logic [W-1:0] f3;
      logic [W-1:0] q;
   } cilc_sync_s;

   cilc_sync_s st_ff;
   cilc_sync_s nxt;

   // A bit moves only when stages two and three agree, so a glitch
   // shorter than two cycles never reaches the slave logic
   always_comb begin
      nxt = st_ff;
      nxt.f1 = i_async;
      nxt.f2 = st_ff.f1;
      nxt.f3 = st_ff.f2;
      for (int i = 0; i < W; i++) begin
         if (st_ff.f2[i] == st_ff.f3[i]) begin
            nxt.q[i] = st_ff.f3[i];
         end
      end
      if (!i_rst_n) begin
         nxt = {4{P_RST}};
      end
   end

   // State register
   always_ff @(posedge i_clk) begin
      st_ff <= nxt;
   end

   assign o_q = st_ff.q;

   property p_sync_agree;
      @(posedge i_clk) disable iff (!i_rst_n)
      (st_ff.f2 == st_ff.f3) |=> (o_q == $past(st_ff.f3));
   endproperty
   a_sync_agree: assert property (p_sync_agree)
      else $error("filtered input did not follow agreeing stages");

endmodule : cilc_sync

// ==== verilog/cilc_blank.sv ====
// Input current limiter blanking window timer
`timescale 1ns/100ps
module cilc_blank
   import cilc_pkg::*;
#(
   parameter int CW = 24,
   parameter int unsigned P_CYC_A = 50000,
   parameter int unsigned P_CYC_B = 100000,
   parameter int unsigned P_CYC_C = 1000000
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Input presence and selected blanking time
   input wire logic i_present,
   input wire logic [1:0] i_sel,
   // Window active
   output logic o_blanking
);

   typedef struct packed {
      logic prev;
      logic blank;
      logic [1:0] sel_lat;
      logic [CW-1:0] cnt;
   } cilc_blank_s;

   cilc_blank_s st_ff;
   cilc_blank_s nxt;

   // Window opens when the input appears and lasts the selected count;
   // the code is latched so a rewrite mid-window cannot stretch it
   always_comb begin
      nxt = st_ff;
      nxt.prev = i_present;
      if (i_present && !st_ff.prev) begin
         nxt.blank = 1'b1;
         nxt.sel_lat = i_sel;
         unique case (i_sel)
            2'h0: nxt.cnt = CW'(BLANK_RESAMPLE_CYC);
            2'h1: nxt.cnt = CW'(P_CYC_A);
            2'h2: nxt.cnt = CW'(P_CYC_B);
            2'h3: nxt.cnt = CW'(P_CYC_C);
         endcase
      end else if (st_ff.blank) begin
         nxt.cnt = st_ff.cnt - CW'(1);
         if (st_ff.cnt == CW'(1)) begin
            nxt.blank = 1'b0;
         end
      end
      if (!i_rst_n) begin
         nxt = '0;
      end
   end

   // State register
   always_ff @(posedge i_clk) begin
      st_ff <= nxt;
   end

   assign o_blanking = st_ff.blank;

   sequence s_short_window;
      o_blanking [*4] ##1 !o_blanking;
   endsequence

   property p_short_blank;
      @(posedge i_clk) disable iff (!i_rst_n)
      ($rose(o_blanking) && st_ff.sel_lat == 2'h0) |-> s_short_window;
   endproperty
   a_short_blank: assert property (p_short_blank)
      else $error("resample-only blanking not four cycles");

   property p_attach_blank;
      @(posedge i_clk) disable iff (!i_rst_n)
      (i_present && !st_ff.prev) |=> o_blanking;
   endproperty
   a_attach_blank: assert property (p_attach_blank)
      else $error("blanking did not start on input attach");

endmodule : cilc_blank

// ==== verilog/cilc_regs.sv ====
// Charger input limit and control registers behind a serial slave port
`timescale 1ns/100ps
module cilc_regs
   import cilc_pkg::*;
#(
   parameter logic [6:0] P_DEV_ADDR = 7'h35, // Arbitrary value
   parameter int unsigned P_BLANK_A_CYC =
      $rtoi(BLANK_A_MS * 1000.0 * CLK_MHZ),
   parameter int unsigned P_BLANK_B_CYC =
      $rtoi(BLANK_B_MS * 1000.0 * CLK_MHZ),
   parameter int unsigned P_BLANK_C_CYC =
      $rtoi(BLANK_C_MS * 1000.0 * CLK_MHZ),
   parameter int unsigned P_TIMEOUT_CYC =
      $rtoi(BUS_TIMEOUT_MS * 1000.0 * CLK_MHZ)
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Serial bus pins
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_out,
   output logic o_sda_oe,
   // Status from the analog side
   input wire logic i_input_present,
   input wire logic i_below_recharge,
   input wire logic i_room_zone,
   // Timer flags held in the flag register
   input wire logic i_watchdog_timer_flag,
   input wire logic i_bus_timeout_flag,
   // Interrupt requests and bus timeout event
   output logic o_watchdog_irq,
   output logic o_bus_timeout_irq,
   output logic o_bus_timeout_pulse,
   // Input limiter
   output logic o_limiter_blanking,
   output logic [2:0] o_limiter_effective,
   // System node
   output logic o_system_discharge_enable,
   output logic [3:0] o_system_min_voltage,
   output logic [1:0] o_system_lockout_threshold,
   // Fast charge currents in mA
   output logic [9:0] o_zone_one_charge_current,
   output logic [9:0] o_zone_two_charge_current,
   // Charger control
   output logic o_charger_on,
   output logic o_charger_autostop,
   output logic o_restart_request,
   output logic o_recharge_monitor_on,
   output logic o_first_phase_allowed,
   output logic o_first_phase_time_limited
);

   localparam int TW = $clog2(P_TIMEOUT_CYC + 1);

   typedef struct packed {
      cilc_state_e st;
      logic scl_q;
      logic sda_q;
      logic [7:0] sh;
      logic [3:0] cnt;
      logic [7:0] tx;
      logic [7:0] ptr;
      logic addr_ph;
      logic have_ptr;
      logic rw;
      logic nack;
      logic drv;
      logic busy;
      logic [TW-1:0] tmo_cnt;
      logic tmo_pulse;
      logic [7:0] evt_mask;
      logic [7:0] lim_a;
      logic [7:0] lim_b;
      logic [7:0] uvolt;
      logic [7:0] zone1;
      logic [7:0] zone2;
      logic [7:0] main;
      logic [9:0] cur1;
      logic [9:0] cur2;
      logic [2:0] eff;
   } cilc_regs_s;

   cilc_regs_s st_ff;
   cilc_regs_s nxt;
   logic [4:0] sync_q;
   logic scl_s;
   logic sda_s;
   logic present_s;
   logic below_s;
   logic room_s;
   logic blanking;
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;
   logic wr_en;
   logic [7:0] rd_data;
   logic [2:0] ceil_code;
   logic [2:0] steady_code;

   // Pins and analog status cross into the clock domain here
   cilc_sync #(
      .W(5),
      .P_RST(RST_SYNC)
   ) u_sync (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_async({i_room_zone, i_below_recharge, i_input_present, i_sda,
                i_scl}),
      .o_q(sync_q)
   );

   assign {room_s, below_s, present_s, sda_s, scl_s} = sync_q;

   // Blanking window after the charger input appears
   cilc_blank #(
      .CW(TW),
      .P_CYC_A(P_BLANK_A_CYC),
      .P_CYC_B(P_BLANK_B_CYC),
      .P_CYC_C(P_BLANK_C_CYC)
   ) u_blank (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_present(present_s),
      .i_sel(st_ff.lim_a[BLANK_LSB +: 2]),
      .o_blanking(blanking)
   );

   // Bus events from the filtered lines
   assign scl_rise = scl_s && !st_ff.scl_q;
   assign scl_fall = !scl_s && st_ff.scl_q;
   assign bus_start = scl_s && st_ff.scl_q && st_ff.sda_q && !sda_s;
   assign bus_stop = scl_s && st_ff.scl_q && !st_ff.sda_q && sda_s;
   assign ceil_code = st_ff.lim_a[CEIL_LSB +: 3];
   assign steady_code = st_ff.lim_a[STEADY_LSB +: 3];

   // Read mux; unmapped addresses answer zero
   always_comb begin
      unique case (st_ff.ptr)
         ADDR_TIMER_EVT_MASK: rd_data = st_ff.evt_mask;
         ADDR_LIMIT_A: rd_data = st_ff.lim_a;
         ADDR_LIMIT_B: rd_data = st_ff.lim_b;
         ADDR_UNDERVOLT: rd_data = st_ff.uvolt;
         ADDR_ZONE_ONE: rd_data = st_ff.zone1;
         ADDR_ZONE_TWO: rd_data = st_ff.zone2;
         ADDR_MAIN_CTRL: rd_data = st_ff.main;
         default: rd_data = 8'h00;
      endcase
   end

   // Slave sequencing, register writes and derived settings
   always_comb begin
      nxt = st_ff;
      wr_en = 1'b0;
      nxt.tmo_pulse = 1'b0;
      nxt.scl_q = scl_s;
      nxt.sda_q = sda_s;
      unique case (st_ff.st)
         S_IDLE: begin
            nxt.drv = 1'b0;
         end
         S_RX: begin
            if (scl_rise) begin
               nxt.sh = {st_ff.sh[6:0], sda_s};
               nxt.cnt = st_ff.cnt + 4'h1;
            end
            if (scl_fall && st_ff.cnt == 4'h8) begin
               nxt.cnt = 4'h0;
               nxt.st = S_ACK_RX;
               nxt.drv = 1'b1;
               if (st_ff.addr_ph) begin
                  nxt.rw = st_ff.sh[0];
                  if (st_ff.sh[7:1] != P_DEV_ADDR) begin
                     nxt.st = S_IDLE;
                     nxt.drv = 1'b0;
                  end
               end else if (!st_ff.have_ptr) begin
                  nxt.ptr = st_ff.sh;
                  nxt.have_ptr = 1'b1;
               end else begin
                  wr_en = 1'b1;
                  nxt.ptr = st_ff.ptr + 8'h01;
               end
            end
         end
         S_ACK_RX: begin
            if (scl_fall) begin
               nxt.addr_ph = 1'b0;
               if (st_ff.addr_ph && st_ff.rw) begin
                  nxt.tx = rd_data;
                  nxt.ptr = st_ff.ptr + 8'h01;
                  nxt.st = S_TX;
                  nxt.drv = ~rd_data[7];
               end else begin
                  nxt.st = S_RX;
                  nxt.drv = 1'b0;
               end
            end
         end
         S_TX: begin
            if (scl_fall) begin
               if (st_ff.cnt == 4'h7) begin
                  nxt.st = S_ACK_TX;
                  nxt.drv = 1'b0;
                  nxt.cnt = 4'h0;
               end else begin
                  nxt.tx = {st_ff.tx[6:0], 1'b0};
                  nxt.drv = ~st_ff.tx[6];
                  nxt.cnt = st_ff.cnt + 4'h1;
               end
            end
         end
         S_ACK_TX: begin
            if (scl_rise) begin
               nxt.nack = sda_s;
            end
            if (scl_fall) begin
               if (st_ff.nack) begin
                  nxt.st = S_IDLE;
               end else begin
                  nxt.tx = rd_data;
                  nxt.ptr = st_ff.ptr + 8'h01;
                  nxt.st = S_TX;
                  nxt.drv = ~rd_data[7];
               end
            end
         end
         default: begin
            nxt.st = S_IDLE;
            nxt.drv = 1'b0;
         end
      endcase
      // Writes keep only the defined bits so reserved ones read zero
      if (wr_en) begin
         unique case (st_ff.ptr)
            ADDR_TIMER_EVT_MASK: nxt.evt_mask = st_ff.sh & WMASK_TIMER_EVT;
            ADDR_LIMIT_A: nxt.lim_a = st_ff.sh & WMASK_LIMIT_A;
            ADDR_LIMIT_B: nxt.lim_b = st_ff.sh & WMASK_LIMIT_B;
            ADDR_UNDERVOLT: nxt.uvolt = st_ff.sh & WMASK_UNDERVOLT;
            ADDR_ZONE_ONE: nxt.zone1 = st_ff.sh & WMASK_ZONE;
            ADDR_ZONE_TWO: nxt.zone2 = st_ff.sh & WMASK_ZONE;
            ADDR_MAIN_CTRL: nxt.main = st_ff.sh & WMASK_MAIN_CTRL;
            default: nxt.ptr = nxt.ptr;
         endcase
      end
      // Start and stop override the byte sequencing
      if (bus_start) begin
         nxt.st = S_RX;
         nxt.addr_ph = 1'b1;
         nxt.have_ptr = 1'b0;
         nxt.cnt = 4'h0;
         nxt.drv = 1'b0;
         nxt.busy = 1'b1;
      end
      if (bus_stop) begin
         nxt.st = S_IDLE;
         nxt.drv = 1'b0;
         nxt.busy = 1'b0;
      end
      // Inactivity watchdog; a stuck master cannot keep the slave busy or driving SDA forever
      if (!st_ff.busy || scl_s != st_ff.scl_q || sda_s != st_ff.sda_q) begin
         nxt.tmo_cnt = '0;
      end else if (st_ff.tmo_cnt == TW'(P_TIMEOUT_CYC - 1)) begin
         nxt.tmo_pulse = 1'b1;
         nxt.tmo_cnt = '0;
         nxt.busy = 1'b0;
         nxt.st = S_IDLE;
         nxt.drv = 1'b0;
      end else begin
         nxt.tmo_cnt = st_ff.tmo_cnt + TW'(1);
      end
      // Decoded currents for both zones
      nxt.cur1 = cilc_code_to_ma(st_ff.zone1[6:0]);
      nxt.cur2 = cilc_code_to_ma(st_ff.zone2[6:0]);
      // Ceiling while blanking, else steady clamped to the ceiling;
      // the charger on bit takes no part here
      if (blanking) begin
         nxt.eff = ceil_code;
      end else if (steady_code > ceil_code) begin
         nxt.eff = ceil_code;
      end else begin
         nxt.eff = steady_code;
      end
      if (!i_rst_n) begin
         nxt = '0;
         nxt.st = S_IDLE;
         nxt.scl_q = 1'b1;
         nxt.sda_q = 1'b1;
         nxt.evt_mask = RST_TIMER_EVT;
         nxt.lim_a = RST_LIMIT_A;
         nxt.lim_b = RST_LIMIT_B;
         nxt.uvolt = RST_UNDERVOLT;
         nxt.zone1 = RST_ZONE;
         nxt.zone2 = RST_ZONE;
         nxt.main = RST_MAIN_CTRL;
         nxt.cur1 = CUR_LO_BASE;
         nxt.cur2 = CUR_LO_BASE;
      end
   end

   // State register
   always_ff @(posedge i_clk) begin
      st_ff <= nxt;
   end

   // Open-drain SDA: only ever pulls low
   assign o_sda_out = 1'b0;
   assign o_sda_oe = st_ff.drv;

   // Masked interrupt requests, 1 lets the flag through
   assign o_watchdog_irq = i_watchdog_timer_flag &&
                           st_ff.evt_mask[WD_MASK_BIT];
   assign o_bus_timeout_irq = i_bus_timeout_flag &&
                              st_ff.evt_mask[BT_MASK_BIT];
   assign o_bus_timeout_pulse = st_ff.tmo_pulse;

   // Settings from the registers and the blanking timer
   assign o_limiter_blanking = blanking;
   assign o_limiter_effective = st_ff.eff;
   assign o_system_discharge_enable = st_ff.lim_b[DISCHARGE_BIT];
   assign o_system_min_voltage = st_ff.lim_b[MINV_LSB +: 4];
   assign o_system_lockout_threshold =
      st_ff.uvolt[LOCKOUT_LSB +: 2];
   assign o_zone_one_charge_current = st_ff.cur1;
   assign o_zone_two_charge_current = st_ff.cur2;
   assign o_charger_on = st_ff.main[CHG_ON_BIT];
   assign o_charger_autostop = st_ff.main[AUTOSTOP_BIT];
   assign o_first_phase_time_limited = st_ff.main[TIME_LIM_BIT];

   // Comparator runs when enabled, or on demand while disabled
   assign o_recharge_monitor_on = st_ff.main[CHG_ON_BIT] ||
                                  st_ff.main[FORCE_MON_BIT];
   assign o_restart_request = st_ff.main[RESTART_BIT] && below_s &&
                              o_recharge_monitor_on;
   assign o_first_phase_allowed = st_ff.main[PHASE1_EN_BIT] &&
      (!st_ff.main[ROOM_ONLY_BIT] || room_s);

   sequence s_released;
      st_ff.st == S_IDLE && !o_sda_oe && !st_ff.busy;
   endsequence

   property p_timeout_release;
      @(posedge i_clk) disable iff (!i_rst_n)
      o_bus_timeout_pulse |-> s_released;
   endproperty
   a_timeout_release: assert property (p_timeout_release)
      else $error("bus timeout did not release the slave");

   property p_main_write;
      @(posedge i_clk) disable iff (!i_rst_n)
      (wr_en && st_ff.ptr == ADDR_MAIN_CTRL) |=>
         (o_charger_on == $past(st_ff.sh[7]) &&
          o_charger_autostop == $past(st_ff.sh[6]));
   endproperty
   a_main_write: assert property (p_main_write)
      else $error("main control write not stored");

   property p_reserved_zero;
      @(posedge i_clk) disable iff (!i_rst_n)
      ((st_ff.lim_b & ~WMASK_LIMIT_B) == 8'h00) &&
      ((st_ff.main & ~WMASK_MAIN_CTRL) == 8'h00) &&
      ((st_ff.evt_mask & ~WMASK_TIMER_EVT) == 8'h00);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved bit became nonzero");

   property p_clamp;
      @(posedge i_clk) disable iff (!i_rst_n)
      (!blanking && $stable(st_ff.lim_a)) |=>
         (o_limiter_effective <= $past(ceil_code));
   endproperty
   a_clamp: assert property (p_clamp)
      else $error("effective limit above ceiling");

   property p_blank_ceiling;
      @(posedge i_clk) disable iff (!i_rst_n)
      (blanking && $stable(st_ff.lim_a)) |=>
         (o_limiter_effective == $past(ceil_code));
   endproperty
   a_blank_ceiling: assert property (p_blank_ceiling)
      else $error("blanking limit not the ceiling");

   property p_saturate;
      @(posedge i_clk) disable iff (!i_rst_n)
      (st_ff.zone1[6:0] > CUR_HI_TOP) |=>
         (o_zone_one_charge_current == 10'h1F4);
   endproperty
   a_saturate: assert property (p_saturate)
      else $error("zone one current did not saturate");

   property p_restart_block;
      @(posedge i_clk) disable iff (!i_rst_n)
      !st_ff.main[RESTART_BIT] |-> !o_restart_request;
   endproperty
   a_restart_block: assert property (p_restart_block)
      else $error("restart requested with auto-restart off");

   property p_mask_gate;
      @(posedge i_clk) disable iff (!i_rst_n)
      !st_ff.evt_mask[BT_MASK_BIT] |-> !o_bus_timeout_irq;
   endproperty
   a_mask_gate: assert property (p_mask_gate)
      else $error("masked bus timeout reached the output");

endmodule : cilc_regs

// ==== bench/cilc_host.sv ====
// Host processor model mastering the serial bus
`timescale 1ns/100ps
module cilc_host #(
   parameter logic [6:0] P_ADDR = 7'h35 // Arbitrary value
) (
   // Clock
   input wire logic i_clk,
   // Bus pins; SDA is open drain with a pull-up
   input wire logic i_sda,
   output logic o_scl,
   output logic o_sda_low
);
   // Bus idles released and high
   initial begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end
   // One bus phase of ten clocks, above the slave's four-cycle input filter delay
   task automatic hp();
      repeat (10) @(posedge i_clk);
      #1;
   endtask : hp
   // Start (a=0, b=1, SCL ends low) or stop (a=1, b=0)
   task automatic cond(input logic a, input logic b);
      hp();
      o_sda_low = a;
      hp();
      o_scl = 1'b1;
      hp();
      o_sda_low = b;
      hp();
      o_scl = !b;
   endtask : cond
   // Nine bits MSB first; data never moves while SCL is high
   task automatic xbyte(input logic [8:0] d, output logic [8:0] q);
      for (int i = 8; i >= 0; i--) begin
         hp();
         o_sda_low = !d[i];
         hp();
         o_scl = 1'b1;
         hp();
         q[i] = i_sda;
         o_scl = 1'b0;
      end
   endtask : xbyte
   // Pointer then one data byte
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      logic [8:0] q;
      cond(1'b0, 1'b1);
      xbyte({P_ADDR, 2'b01}, q);
      xbyte({a, 1'b1}, q);
      xbyte({v, 1'b1}, q);
      cond(1'b1, 1'b0);
   endtask : wr
   // Pointer, repeated start, one byte closed by NACK
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      logic [8:0] q;
      cond(1'b0, 1'b1);
      xbyte({P_ADDR, 2'b01}, q);
      xbyte({a, 1'b1}, q);
      cond(1'b0, 1'b1);
      xbyte({P_ADDR, 2'b11}, q);
      xbyte(9'h1FF, q);
      v = q[8:1];
      cond(1'b1, 1'b0);
   endtask : rd
endmodule : cilc_host

// ==== bench/testbench.sv ====
// Self-checking bench for the charger input limit registers
`timescale 1ns/100ps
module testbench
   import cilc_pkg::*;
;
   logic clk, rst_n, scl, hlow, pres, oe, pul, seen;
   logic bel, rm, wdf, btf;
   logic [8:0] q9;
   logic wd, bt, blk, dis, on, ast, rrq, mon, alw, tl;
   logic [2:0] eff;
   logic [3:0] minv;
   logic [1:0] lock;
   logic [9:0] z1, z2;
   logic [7:0] v, x;
   logic [15:0] e1, e2;
   int n;
   int num_errors = 0;
   int total_checks = 0;
   logic [7:0] ar [7] = '{8'h12, 8'h13, 8'h14, 8'h16, 8'h17, 8'h18, 8'h19};
   logic [7:0] wm [7] = '{8'h81, 8'hFF, 8'h2F, 8'hC0, 8'h7F, 8'h7F, 8'hEF};
   logic [7:0] cc [6] = '{8'h00, 8'h01, 8'h3F, 8'h40, 8'h64, 8'h65};
   logic [15:0] ma [6] = '{16'h4, 16'h6, 16'h82, 16'h8C, 16'h1F4, 16'h1F4};
   logic [15:0] bl [4] = '{16'h4, 16'h14, 16'h28, 16'h50};
   logic [7:0] cv [6] = '{8'h80, 8'h28, 8'hA0, 8'h47, 8'h05, 8'h09};
   // Open drain line: low if either side pulls it
   wire logic sda = !(hlow | oe);
   cilc_regs #(.P_BLANK_A_CYC(20), .P_BLANK_B_CYC(40),
      .P_BLANK_C_CYC(80), .P_TIMEOUT_CYC(200)) u_dut (
      .i_clk(clk), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda),
      .o_sda_out(), .o_sda_oe(oe), .i_input_present(pres),
      .i_below_recharge(bel), .i_room_zone(rm),
      .i_watchdog_timer_flag(wdf), .i_bus_timeout_flag(btf),
      .o_watchdog_irq(wd), .o_bus_timeout_irq(bt),
      .o_bus_timeout_pulse(pul), .o_limiter_blanking(blk),
      .o_limiter_effective(eff), .o_system_discharge_enable(dis),
      .o_system_min_voltage(minv), .o_system_lockout_threshold(lock),
      .o_zone_one_charge_current(z1), .o_zone_two_charge_current(z2),
      .o_charger_on(on), .o_charger_autostop(ast), .o_restart_request(rrq),
      .o_recharge_monitor_on(mon), .o_first_phase_allowed(alw),
      .o_first_phase_time_limited(tl));
   cilc_host u_host (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(hlow));
   // Free-running clock, 10 ns period
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // The timeout event lasts one cycle, so latch it
   always @(posedge clk) seen <= rst_n && (seen || pul);
   // Compare and count
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value at %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   // Counts, verdict and end of run
   task automatic end_sim();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : end_sim
   // Watchdog: the tests need roughly 0.5 ms
   initial begin
      #1_000_000;
      num_errors++;
      end_sim();
   end
   // Test sequence
   initial begin
      rst_n = 1'b0;
      pres = 1'b0;
      bel = 1'b1;
      rm = 1'b0;
      wdf = 1'b1;
      btf = 1'b1;
      repeat (8) @(posedge clk);
      #1;
      rst_n = 1'b1;
      repeat (8) @(posedge clk);
      for (int i = 0; i < 7; i++) begin
         u_host.rd(ar[i], v);
         chk(16'(v), 16'h0);
         u_host.wr(ar[i], 8'hFF);
         u_host.rd(ar[i], v);
         chk(16'(v), 16'(wm[i]));
      end
      chk(16'({dis, minv, lock}), 16'h7F);
      u_host.wr(8'h15, 8'hFF);
      u_host.rd(8'h15, v);
      chk(16'(v), 16'h0);
      u_host.wr(8'h12, 8'h80);
      chk(16'({wd, bt}), 16'h2);
      wdf = 1'b0;
      u_host.wr(8'h12, 8'h81);
      chk(16'({wd, bt}), 16'h1);
      $display("test registers done");
      for (int i = 0; i < 6; i++) begin
         u_host.wr(8'h17, cc[i]);
         u_host.wr(8'h18, cc[i]);
         chk(16'(z1), ma[i]);
         chk(16'(z2), ma[i]);
      end
      // Burst write then burst read: pointer steps, master acks byte one
      u_host.cond(1'b0, 1'b1);
      u_host.xbyte({u_host.P_ADDR, 2'b01}, q9);
      u_host.xbyte({8'h17, 1'b1}, q9);
      u_host.xbyte({8'h05, 1'b1}, q9);
      u_host.xbyte({8'h06, 1'b1}, q9);
      u_host.cond(1'b1, 1'b0);
      chk(16'(z1), 16'hE);
      chk(16'(z2), 16'h10);
      u_host.cond(1'b0, 1'b1);
      u_host.xbyte({u_host.P_ADDR, 2'b01}, q9);
      u_host.xbyte({8'h17, 1'b1}, q9);
      u_host.cond(1'b0, 1'b1);
      u_host.xbyte({u_host.P_ADDR, 2'b11}, q9);
      u_host.xbyte(9'h1FE, q9);
      chk(16'(q9[8:1]), 16'h05);
      u_host.xbyte(9'h1FF, q9);
      chk(16'(q9[8:1]), 16'h06);
      u_host.cond(1'b1, 1'b0);
      $display("test currents done");
      u_host.wr(8'h13, 8'h1E);
      chk(16'(eff), 16'h3);
      for (int k = 0; k < 4; k++) begin
         pres = 1'b0;
         u_host.wr(8'h13, {k[1:0], 6'h19});
         chk(16'(eff), 16'h1);
         pres = 1'b1;
         n = 0;
         repeat (100) begin
            @(posedge clk);
            #1;
            n += int'(blk === 1'b1);
            if (n == 2) chk(16'(eff), 16'h3);
         end
         chk(16'(n), bl[k]);
      end
      $display("test limiter done");
      for (int i = 0; i < 6; i++) begin
         bel = i[0];
         rm = i[1];
         u_host.wr(8'h19, cv[i]);
         x = cv[i];
         e1 = 16'({x[7], x[6], x[1], 3'h1});
         e2 = 16'({x[7] | x[3], x[5] & (x[7] | x[3]) & bel,
            x[0] & (!x[2] | rm)});
         chk(16'({on, ast, tl, eff}), e1);
         chk(16'({mon, rrq, alw}), e2);
      end
      $display("test control done");
      u_host.cond(1'b0, 1'b1);
      repeat (150) @(posedge clk);
      #1;
      chk(16'(seen), 16'h0);
      repeat (110) @(posedge clk);
      #1;
      chk(16'(seen), 16'h1);
      u_host.cond(1'b1, 1'b0);
      $display("test timeout done");
      end_sim();
   end
endmodule : testbench
